// file: hw/avsw_pkg.sv
// Shared constants for the audio/video switch serial control block.
package avsw_pkg;

    // ------------------------------------------------------------------
    // Serial slave addresses (8-bit form, write direction)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STRAP_LOW  = 8'h90;
    localparam logic [7:0] ADDR_STRAP_HIGH = 8'h92;

    // ------------------------------------------------------------------
    // Serial control bit positions inside the control image
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_BITS   = 64;
    localparam int unsigned BIT_PORT1   = 53;
    localparam int unsigned BIT_PORT2   = 52;
    localparam int unsigned BIT_PORT3   = 51;
    localparam int unsigned BIT_PORT4   = 50;
    localparam int unsigned BIT_GAIN1   = 46;
    localparam int unsigned BIT_GAIN2   = 45;
    localparam int unsigned BIT_GAIN3   = 44;
    localparam int unsigned CTRL_BYTES  = 8;
    localparam int unsigned STAT_BYTES  = 2;

    // ------------------------------------------------------------------
    // AXI4-Lite register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_LO  = 8'h00;
    localparam logic [7:0] OFS_CTRL_HI  = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_CONFIG   = 8'h0C;
    localparam logic [31:0] CTRL_LO_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_HI_RST = 32'h003C_0000;

    // Status word layout.
    localparam int unsigned ST_PRES_LSB = 0;
    localparam int unsigned ST_LVL_LSB  = 4;

    // Three-level detector encoding.
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : avsw_pkg

// file: hw/avsw_i2c_slave.sv
// Serial two-wire slave: control bytes in, status bytes out.
`timescale 1ns/1ps

module avsw_i2c_slave
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [7:0]  dev_addr_i,
    // Register side
    output logic             wr_stb_o,
    output logic [2:0]       wr_idx_o,
    output logic [7:0]       wr_data_o,
    input  wire logic [15:0] status_i
);

    typedef enum logic [4:0]
    {
        AVSW_IDLE = 5'b00001,
        AVSW_ADDR = 5'b00010,
        AVSW_WR   = 5'b00100,
        AVSW_RD   = 5'b01000,
        AVSW_ACK  = 5'b10000
    } avsw_st_t;

    avsw_st_t    st_r,    st_nxt;
    logic        scl_r,   sda_r;
    logic [7:0]  sh_r,    sh_nxt;
    logic [3:0]  cnt_r,   cnt_nxt;
    logic [2:0]  idx_r,   idx_nxt;
    logic        rd_r,    rd_nxt;
    logic        oe_r,    oe_nxt;
    logic        ackd_r,  ackd_nxt;
    logic        stb_r,   stb_nxt;
    logic [7:0]  dat_r,   dat_nxt;

    wire scl_rise = scl_i & ~scl_r;
    wire scl_fall = ~scl_i & scl_r;
    wire start    = scl_i & scl_r & sda_r & ~sda_i;
    wire stop     = scl_i & scl_r & ~sda_r & sda_i;

    always_comb
    begin
        st_nxt   = st_r;
        sh_nxt   = sh_r;
        cnt_nxt  = cnt_r;
        idx_nxt  = idx_r;
        rd_nxt   = rd_r;
        oe_nxt   = oe_r;
        ackd_nxt = ackd_r;
        stb_nxt  = 1'b0;
        dat_nxt  = dat_r;
        if (start)
        begin
            st_nxt  = AVSW_ADDR;
            cnt_nxt = 4'h0;
            idx_nxt = 3'h0;
            oe_nxt  = 1'b0;
        end
        else if (stop)
        begin
            st_nxt = AVSW_IDLE;
            oe_nxt = 1'b0;
        end
        else
        begin
            case (st_r)
                AVSW_IDLE: st_nxt = AVSW_IDLE;
                AVSW_ADDR, AVSW_WR:
                begin
                    if (scl_rise)
                    begin
                        sh_nxt  = {sh_r[6:0], sda_i};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == 4'h8)
                    begin
                        cnt_nxt = 4'h0;
                        if (st_r == AVSW_ADDR)
                        begin
                            // Only the strapped address is answered.
                            if (sh_r[7:1] == dev_addr_i[7:1])
                            begin
                                rd_nxt   = sh_r[0];
                                oe_nxt   = 1'b1;
                                ackd_nxt = 1'b1;
                                st_nxt   = AVSW_ACK;
                            end
                            else
                                st_nxt = AVSW_IDLE;
                        end
                        else
                        begin
                            // Written bytes go to the control image.
                            stb_nxt  = 1'b1;
                            dat_nxt  = sh_r;
                            oe_nxt   = 1'b1;
                            ackd_nxt = 1'b0;
                            st_nxt   = AVSW_ACK;
                        end
                    end
                end
                AVSW_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_nxt  = 1'b0;
                        cnt_nxt = 4'h0;
                        if (!ackd_r)
                            idx_nxt = idx_r + 3'h1;
                        if (rd_r)
                        begin
                            // Reads come from the status bytes.
                            sh_nxt = idx_r[0] ? status_i[15:8]
                                              : status_i[7:0];
                            oe_nxt = ~sh_nxt[7];
                            st_nxt = AVSW_RD;
                        end
                        else
                            st_nxt = AVSW_WR;
                    end
                end
                AVSW_RD:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = cnt_r + 4'h1;
                        sh_nxt  = {sh_r[6:0], 1'b1};
                        oe_nxt  = (cnt_r < 4'h7) ? ~sh_r[6] : 1'b0;
                    end
                    if (scl_rise && cnt_r == 4'h8)
                    begin
                        if (sda_i)
                            st_nxt = AVSW_IDLE;
                        else
                        begin
                            idx_nxt  = idx_r + 3'h1;
                            ackd_nxt = 1'b1;
                            st_nxt   = AVSW_ACK;
                        end
                    end
                end
                default: st_nxt = AVSW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            st_r   <= AVSW_IDLE;
            scl_r  <= 1'b1;
            sda_r  <= 1'b1;
            sh_r   <= 8'h00;
            cnt_r  <= 4'h0;
            idx_r  <= 3'h0;
            rd_r   <= 1'b0;
            oe_r   <= 1'b0;
            ackd_r <= 1'b0;
            stb_r  <= 1'b0;
            dat_r  <= 8'h00;
        end
        else
        begin
            st_r   <= st_nxt;
            scl_r  <= scl_i;
            sda_r  <= sda_i;
            sh_r   <= sh_nxt;
            cnt_r  <= cnt_nxt;
            idx_r  <= idx_nxt;
            rd_r   <= rd_nxt;
            oe_r   <= oe_nxt;
            ackd_r <= ackd_nxt;
            stb_r  <= stb_nxt;
            dat_r  <= dat_nxt;
        end
    end

    assign sda_o     = 1'b0;
    assign sda_oe_o  = oe_r;
    assign wr_stb_o  = stb_r;
    assign wr_idx_o  = idx_r;
    assign wr_data_o = dat_r;

endmodule // avsw_i2c_slave

// file: hw/avsw_ctrl.sv
// Control and status bank of the audio/video switch.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps


module avsw_ctrl
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Serial pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        addr_strap_i,
    // Detect inputs (comparator outputs)
    input  wire logic [3:0]  connector_presence_detect_i,
    input  wire logic [3:0]  aspect_function_above_low_i,
    input  wire logic [3:0]  aspect_function_above_high_i,
    // Open-collector output ports, index 0 is port one
    output logic [3:0]       general_output_port_o,
    output logic [3:0]       general_output_port_oe_o,
    // Line output gain select, 1 means 6 dB
    output logic [2:0]       audio_line_gain_6db_o,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------------
    // Control image and detector status
    // ------------------------------------------------------------------
    logic [63:0] ctrl_r,     ctrl_nxt;
    logic        strap_r,    strap_nxt;
    logic [15:0] status_w;
    logic        i2c_stb;
    logic [2:0]  i2c_idx;
    logic [7:0]  i2c_dat;

    // Presence: a grounded connector reads 1 (connected).
    assign status_w[avsw_pkg::ST_PRES_LSB +: 4] =
        ~connector_presence_detect_i;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lvl
            // Two thresholds give three levels; an impossible mix
            // (above high, not above low) is reported as high.
            assign status_w[avsw_pkg::ST_LVL_LSB + 2*g +: 2] =
                aspect_function_above_high_i[g] ? avsw_pkg::LVL_HIGH :
                aspect_function_above_low_i[g]  ? avsw_pkg::LVL_MID  :
                                                  avsw_pkg::LVL_LOW;
        end
    endgenerate

    assign status_w[15:12] = 4'h0;

    avsw_i2c_slave u_i2c
    (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe_o),
        .dev_addr_i (strap_r ? avsw_pkg::ADDR_STRAP_HIGH
                             : avsw_pkg::ADDR_STRAP_LOW),
        .wr_stb_o   (i2c_stb),
        .wr_idx_o   (i2c_idx),
        .wr_data_o  (i2c_dat),
        .status_i   (status_w)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic        aw_r,    aw_nxt;
    logic [7:0]  awa_r,   awa_nxt;
    logic        w_r,     w_nxt;
    logic [31:0] wd_r,    wd_nxt;
    logic [3:0]  ws_r,    ws_nxt;
    logic        bv_r,    bv_nxt;
    logic [1:0]  br_r,    br_nxt;
    logic        rv_r,    rv_nxt;
    logic [31:0] rd_r,    rd_nxt;
    logic [1:0]  rr_r,    rr_nxt;
    logic        do_wr;
    logic [31:0] wmask;

    assign s_axi_awready = ~aw_r & ~bv_r;
    assign s_axi_wready  = ~w_r & ~bv_r;
    assign s_axi_arready = ~rv_r;
    assign do_wr         = aw_r & w_r & ~bv_r;
    assign wmask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};

    always_comb
    begin
        aw_nxt    = aw_r;
        awa_nxt   = awa_r;
        w_nxt     = w_r;
        wd_nxt    = wd_r;
        ws_nxt    = ws_r;
        bv_nxt    = bv_r;
        br_nxt    = br_r;
        rv_nxt    = rv_r;
        rd_nxt    = rd_r;
        rr_nxt    = rr_r;
        ctrl_nxt  = ctrl_r;
        strap_nxt = strap_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_nxt  = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_nxt  = 1'b1;
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
        end
        // Serial writes land byte by byte; bits otherwise hold.
        if (i2c_stb)
            ctrl_nxt[i2c_idx*8 +: 8] = i2c_dat;
        if (do_wr)
        begin
            aw_nxt = 1'b0;
            w_nxt  = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = avsw_pkg::RESP_OKAY;
            case (awa_r[7:2])
                avsw_pkg::OFS_CTRL_LO[7:2]:
                    ctrl_nxt[31:0] = (ctrl_r[31:0] & ~wmask)
                                   | (wd_r & wmask);
                avsw_pkg::OFS_CTRL_HI[7:2]:
                    ctrl_nxt[63:32] = (ctrl_r[63:32] & ~wmask)
                                    | (wd_r & wmask);
                avsw_pkg::OFS_CONFIG[7:2]:
                    if (ws_r[0])
                        strap_nxt = wd_r[0];
                avsw_pkg::OFS_STATUS[7:2]: br_nxt = avsw_pkg::RESP_OKAY;
                default: br_nxt = avsw_pkg::RESP_SLVERR;
            endcase
        end
        if (bv_r && s_axi_bready)
            bv_nxt = 1'b0;
        if (rv_r && s_axi_rready)
            rv_nxt = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rv_nxt = 1'b1;
            rr_nxt = avsw_pkg::RESP_OKAY;
            case (s_axi_araddr[7:2])
                avsw_pkg::OFS_CTRL_LO[7:2]: rd_nxt = ctrl_r[31:0];
                avsw_pkg::OFS_CTRL_HI[7:2]: rd_nxt = ctrl_r[63:32];
                avsw_pkg::OFS_STATUS[7:2]:  rd_nxt = {16'h0000, status_w};
                avsw_pkg::OFS_CONFIG[7:2]:  rd_nxt = {31'h0, strap_r};
                default:
                begin
                    rd_nxt = 32'h0000_0000;
                    rr_nxt = avsw_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Strap is sampled on every reset cycle; outside reset only a CONFIG write changes it.
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ctrl_r  <= {avsw_pkg::CTRL_HI_RST, avsw_pkg::CTRL_LO_RST};
            strap_r <= addr_strap_i;
            aw_r    <= 1'b0;
            awa_r   <= 8'h00;
            w_r     <= 1'b0;
            wd_r    <= 32'h0000_0000;
            ws_r    <= 4'h0;
            bv_r    <= 1'b0;
            br_r    <= 2'h0;
            rv_r    <= 1'b0;
            rd_r    <= 32'h0000_0000;
            rr_r    <= 2'h0;
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            strap_r <= strap_nxt;
            aw_r    <= aw_nxt;
            awa_r   <= awa_nxt;
            w_r     <= w_nxt;
            wd_r    <= wd_nxt;
            ws_r    <= ws_nxt;
            bv_r    <= bv_nxt;
            br_r    <= br_nxt;
            rv_r    <= rv_nxt;
            rd_r    <= rd_nxt;
            rr_r    <= rr_nxt;
        end
    end

    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp  = br_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata  = rd_r;
    assign s_axi_rresp  = rr_r;

    // ------------------------------------------------------------------
    // Outputs: a 0 port bit pulls the port low, a 1 releases it; gain bits drive the gain selects directly
    // ------------------------------------------------------------------
    assign general_output_port_o = 4'h0;
    assign general_output_port_oe_o =
    {
        ~ctrl_r[avsw_pkg::BIT_PORT4],
        ~ctrl_r[avsw_pkg::BIT_PORT3],
        ~ctrl_r[avsw_pkg::BIT_PORT2],
        ~ctrl_r[avsw_pkg::BIT_PORT1]
    };
    assign audio_line_gain_6db_o[0] = ctrl_r[avsw_pkg::BIT_GAIN1];
    assign audio_line_gain_6db_o[1] = ctrl_r[avsw_pkg::BIT_GAIN2];
    assign audio_line_gain_6db_o[2] = ctrl_r[avsw_pkg::BIT_GAIN3];

endmodule // avsw_ctrl

// file: bench/avsw_i2c_mst.sv
// Behavioural two-wire bus master that drives the serial control port.
`timescale 1ns/1ps

module avsw_i2c_mst
(
    // Clock and bus levels, a driven 1 releases the line
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Six clocks a phase, so the slave sees every level after its sampling.
    localparam int PH = 6;

    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_ph();
        repeat (PH) @(posedge clk_i);
    endtask

    task automatic bit_io(input logic b, output logic r);
        @(posedge clk_i);
        sda_o <= b;
        wait_ph();
        scl_o <= 1'b1;
        wait_ph();
        r = sda_i;
        scl_o <= 1'b0;
    endtask

    task automatic start_bit();
        @(posedge clk_i);
        sda_o <= 1'b1;
        wait_ph();
        scl_o <= 1'b1;
        wait_ph();
        sda_o <= 1'b0;
        wait_ph();
        scl_o <= 1'b0;
    endtask

    task automatic stop_bit();
        @(posedge clk_i);
        sda_o <= 1'b0;
        wait_ph();
        scl_o <= 1'b1;
        wait_ph();
        sda_o <= 1'b1;
        wait_ph();
    endtask

    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // Detect results reach the master only through these status reads.
    task automatic get_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, v[i]);
        bit_io(last, r);
    endtask
endmodule // avsw_i2c_mst

// file: bench/avsw_ctrl_assertions.sv
// Concurrent checks on the ports of the control and status bank.
`timescale 1ns/1ps

module avsw_ctrl_chk
(
    // Clock, reset and serial pins
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        scl_i,
    input wire logic        sda_oe_o,
    // Detects and controlled outputs
    input wire logic [3:0]  connector_presence_detect_i,
    input wire logic [3:0]  general_output_port_o,
    input wire logic [3:0]  general_output_port_oe_o,
    input wire logic [2:0]  audio_line_gain_6db_o,
    // Register bus
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    port_low_a: assert property (general_output_port_o == 4'h0)
        else $error("open-collector level not low");
    rst_vals_a: assert property ($rose(nrst_i) |->
        general_output_port_oe_o == 4'h0 && audio_line_gain_6db_o == 3'h0)
        else $error("outputs not at reset values");
    port_hold_a: assert property ($changed(general_output_port_oe_o) |->
        $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || !$past(scl_i))
        else $error("output port moved without a write");
    gain_hold_a: assert property (!$past(s_axi_wvalid) && scl_i
        && !$past(s_axi_wvalid, 2) && $past(scl_i) && $past(scl_i, 2)
        |-> $stable(audio_line_gain_6db_o))
        else $error("line gain moved without a write");
    sda_stand_a: assert property (scl_i && $past(scl_i) && $past(scl_i, 2)
        |-> $stable(sda_oe_o))
        else $error("data line moved while clock high");
    bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    rhold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    rlat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    blat_a: assert property (s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    bad_rd_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] > 6'h03 |=> s_axi_rdata == 32'h0000_0000
        && s_axi_rresp == avsw_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    stat_rd_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == avsw_pkg::OFS_STATUS
        |=> s_axi_rdata[3:0] == ~$past(connector_presence_detect_i))
        else $error("presence status wrong");
endmodule // avsw_ctrl_chk

// file: bench/avsw_ctrl_bench.sv
// Self-checking bench for the control and status bank of the AV switch.
`timescale 1ns/1ps

module avsw_ctrl_bench;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic        clk_i = 1'b0, nrst_i = 1'b0, addr_strap_i = 1'b0;
    logic [3:0]  connector_presence_detect_i = 4'hF;
    logic [3:0]  aspect_function_above_low_i = 4'h0;
    logic [3:0]  aspect_function_above_high_i = 4'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_rready = 1'b0, mst_sda, scl_i, sda_o, sda_oe_o;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [3:0]  general_output_port_o, general_output_port_oe_o;
    logic [2:0]  audio_line_gain_6db_o;
    logic [63:0] c;
    int          error_cnt = 0;
    int          n_compared = 0;
    wire         sda_i = mst_sda & ~(sda_oe_o & ~sda_o);

    always #25 clk_i = ~clk_i;

    avsw_i2c_mst u_avsw_i2c_mst (.clk_i, .sda_i, .scl_o(scl_i),
        .sda_o(mst_sda));
    avsw_ctrl u_avsw_ctrl (.clk_i, .nrst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
        .addr_strap_i, .connector_presence_detect_i,
        .aspect_function_above_low_i, .aspect_function_above_high_i,
        .general_output_port_o, .general_output_port_oe_o,
        .audio_line_gain_6db_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic reset_dut(input logic strap);
        nrst_i <= 1'b0;
        addr_strap_i <= strap;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
    endtask

    // Ready follows valid by a cycle so every answer must hold while stalled.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end
        while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end
        while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic chk_outs();
        repeat (2) @(posedge clk_i);
        chk(general_output_port_oe_o, 4'(~{c[avsw_pkg::BIT_PORT4],
            c[avsw_pkg::BIT_PORT3], c[avsw_pkg::BIT_PORT2],
            c[avsw_pkg::BIT_PORT1]}));
        chk(audio_line_gain_6db_o, {c[avsw_pkg::BIT_GAIN3],
            c[avsw_pkg::BIT_GAIN2], c[avsw_pkg::BIT_GAIN1]});
    endtask

    task automatic i2c_wr(input logic [7:0] a, input logic exp, input int n);
        logic ack;
        u_avsw_i2c_mst.start_bit();
        u_avsw_i2c_mst.put_byte(a, ack);
        chk(ack, exp);
        for (int i = 0; i < n && ack; i++)
        begin
            c[8 * i +: 8] = 8'(8'h25 * i + 8'h13);
            u_avsw_i2c_mst.put_byte(c[8 * i +: 8], ack);
            chk(ack, 1'b1);
        end
        u_avsw_i2c_mst.stop_bit();
    endtask

    function automatic logic [15:0] stat_exp();
        logic [15:0] s;
        s = 16'h0000;
        s[3:0] = ~connector_presence_detect_i;
        for (int g = 0; g < 4; g++)
            s[4 + 2 * g +: 2] = aspect_function_above_high_i[g]
                ? avsw_pkg::LVL_HIGH : aspect_function_above_low_i[g]
                ? avsw_pkg::LVL_MID : avsw_pkg::LVL_LOW;
        return s;
    endfunction

    task automatic stat_case(input logic [3:0] p, lo, hi);
        logic [7:0] b0, b1;
        logic       ack;
        @(posedge clk_i);
        connector_presence_detect_i <= p;
        aspect_function_above_low_i <= lo;
        aspect_function_above_high_i <= hi;
        u_avsw_i2c_mst.start_bit();
        u_avsw_i2c_mst.put_byte(8'h91, ack);
        chk(ack, 1'b1);
        u_avsw_i2c_mst.get_byte(1'b0, b0);
        u_avsw_i2c_mst.get_byte(1'b1, b1);
        u_avsw_i2c_mst.stop_bit();
        chk({b1, b0}, stat_exp());
        axi_rd(avsw_pkg::OFS_STATUS);
        chk(d, stat_exp());
    endtask

    initial
    begin
        repeat (30000) @(posedge clk_i);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        reset_dut(1'b0);
        c = {avsw_pkg::CTRL_HI_RST, avsw_pkg::CTRL_LO_RST};
        chk_outs();
        for (int v = 0; v < 16; v++)
        begin
            c[63:32] = (32'(v) << 18) | (32'(v % 8) << 12);
            axi_wr(avsw_pkg::OFS_CTRL_HI, c[63:32]);
            chk(r, avsw_pkg::RESP_OKAY);
            chk_outs();
        end
        i2c_wr(8'h90, 1'b1, 7);
        chk_outs();
        axi_rd(avsw_pkg::OFS_CTRL_LO);
        chk(d, c[31:0]);
        axi_rd(avsw_pkg::OFS_CTRL_HI);
        chk(d, c[63:32]);
        i2c_wr(8'h92, 1'b0, 1);
        chk_outs();
        stat_case(4'hA, 4'hE, 4'hC);
        stat_case(4'h5, 4'h7, 4'h1);
        axi_rd(8'h10);
        chk({d, r}, {32'h0000_0000, avsw_pkg::RESP_SLVERR});
        axi_wr(8'h10, 32'hFFFF_FFFF);
        chk(r, avsw_pkg::RESP_SLVERR);
        chk_outs();
        reset_dut(1'b1);
        axi_rd(avsw_pkg::OFS_CONFIG);
        chk(d, 32'h0000_0001);
        c = {avsw_pkg::CTRL_HI_RST, avsw_pkg::CTRL_LO_RST};
        chk_outs();
        i2c_wr(8'h90, 1'b0, 1);
        i2c_wr(8'h92, 1'b1, 1);
        axi_rd(avsw_pkg::OFS_CTRL_LO);
        chk(d, c[31:0]);
        report_and_stop();
    end
endmodule // avsw_ctrl_bench

bind avsw_ctrl avsw_ctrl_chk u_avsw_ctrl_chk (.clk_i, .nrst_i, .scl_i,
    .sda_oe_o, .connector_presence_detect_i, .general_output_port_o,
    .general_output_port_oe_o, .audio_line_gain_6db_o, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
